// [bench/nhc_flash_model.sv]
/* Behavioural flash part facing nhc_host: one page buffer, busy line, lock.
   Assumes the host's registered pins; the part has no clock of its own. */
`timescale 1ns/1ps
module nhc_flash_model #(
    parameter int DW      = 16,
    parameter int BUSY_NS = 500,
    parameter int HOLD_NS = 30
) (
    input  wire logic          chipSelectN,
    input  wire logic          cmdLatch,
    input  wire logic          addrLatch,
    input  wire logic          inputStrobeN,
    input  wire logic          output_strobe_n,
    input  wire logic          programLockN,
    input  wire logic [DW-1:0] ioOut,
    output logic      [DW-1:0] ioIn,
    output logic               busy_flag_n
);
    // ==========================================================
    // State
    logic [7:0]    lastCmd = 8'h00;
    logic [7:0]    addrByte [4];
    logic [DW-1:0] page     [264];  // Main words then spare words
    logic [DW-1:0] last    = '0;
    logic          busy    = 1'b0;
    logic          drive   = 1'b0;
    logic          powerGood = 1'b1;  // Supply detector output; low blocks latching and read strobes.
    int            addrCnt = 0;
    int            col     = 0;
    int            progCount = 0;

    // Erased cells read as all ones.
    initial foreach (page[i]) page[i] = '1;

    // Holds the busy state for the configured time.
    task automatic pulse;
        busy = 1'b1;
        #(BUSY_NS) busy = 1'b0;
    endtask : pulse

    // Input strobe rise latches a command, address or data while selected.
    always @(posedge inputStrobeN) begin
        if (!chipSelectN && !busy && powerGood) begin
            if (cmdLatch && !addrLatch) begin
                if (ioOut[7:0] == 8'h10 && lastCmd == 8'h80 && programLockN) begin
                    progCount++;
                    fork pulse(); join_none
                end
                lastCmd = ioOut[7:0];
                addrCnt = 0;
            end else if (addrLatch && !cmdLatch) begin
                if (addrCnt < 4) addrByte[addrCnt] = ioOut[7:0];
                if (addrCnt == 0) col = ioOut[7:0];
                if (addrCnt == 3 && lastCmd == 8'h00) fork pulse(); join_none
                addrCnt++;
            end else if (!addrLatch && !cmdLatch) begin
                page[col % 264] = ioOut;
                col++;
            end
        end
    end

    // Output strobe fall presents the next word and moves the column on.
    always @(negedge output_strobe_n) begin
        if (!chipSelectN && !cmdLatch && !addrLatch && inputStrobeN && !busy && powerGood) begin
            last = page[col % 264];
            drive = 1'b1;
            col++;
        end
    end

    // Data stays a short hold time after the strobe rises, then the lanes let go.
    always @(posedge output_strobe_n) #(HOLD_NS) drive = 1'b0;

    // Deselect when idle drops the outputs.
    always @(posedge chipSelectN) if (!busy) drive = 1'b0;

    // Released lanes show the inverse of the last word; busy is driven low while the part works and high otherwise.
    assign ioIn        = drive ? last : ~last;
    assign busy_flag_n = busy ? 1'b0 : 1'b1;
endmodule : nhc_flash_model

// [bench/nhc_host_bench.sv]
/* Self-checking bench for nhc_host against the behavioural flash model.
   Assumes the package, header and design modules compile ahead of it. */
`timescale 1ns/1ps
module nhc_host_bench;
    import nhc_pkg::*;
    // ==========================================================
    // Signals
    typedef struct {logic [2:0] op; logic [15:0] d; logic [31:0] a;} nhc_row_s;
    logic        clock = 0, rstn = 0, reqValid = 0, protectReq = 0, rdReady = 0;
    logic [2:0]  reqOp   = 3'h0;
    logic [15:0] reqData = 16'h0000;
    logic [31:0] reqAddr = 32'h0000_0000;
    logic        reqReady, rdValid, flashReady, chipSelectN, cmdLatch, addrLatch;
    logic        inputStrobeN, output_strobe_n, programLockN, ioOe, busy_flag_n;
    logic [15:0] rdData, ioOut, ioIn, flashIo;
    int          mismatches = 0, checks = 0, n, col, k, p;
    localparam logic [31:0] AD = 32'h0655_AA03;
    nhc_row_s rows[6] = '{'{NHC_OP_CMD, 16'h0080, 0}, '{NHC_OP_ADDR, 16'h0000, AD},
        '{NHC_OP_WRITE, 16'h1234, 0}, '{NHC_OP_WRITE, 16'hA5C3, 0},
        '{NHC_OP_WRITE, 16'hFFFF, 0}, '{NHC_OP_WRITE, 16'h0000, 0}};

    // Wire level seen by the host: its own drive wins while enabled.
    assign ioIn = ioOe ? ioOut : flashIo;
    always #5 clock = ~clock;

    nhc_host #(.DW(16)) dut_u (.clock, .rstn, .reqValid, .reqReady, .reqOp, .reqData, .reqAddr,
        .protectReq, .rdValid, .rdReady, .rdData, .flashReady, .chipSelectN, .cmdLatch, .addrLatch,
        .inputStrobeN, .output_strobe_n, .programLockN, .ioOut, .ioOe, .ioIn, .busy_flag_n);
    nhc_flash_model m_u (.chipSelectN, .cmdLatch, .addrLatch, .inputStrobeN, .output_strobe_n,
        .programLockN, .ioOut, .ioIn(flashIo), .busy_flag_n);

    // ==========================================================
    // Tasks
    task check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict;
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // Waits at falling edges until a level is seen, bounded.
    task automatic waitfor(ref logic s, input logic v);
        n = 0;
        do begin @(negedge clock); n++; end while (s !== v && n < 400);
    endtask : waitfor
    // Presents one request and holds it until the taking edge.
    task req(logic [2:0] op, logic [15:0] d, logic [31:0] a);
        @(posedge clock);
        reqOp <= op; reqData <= d; reqAddr <= a; reqValid <= 1'b1;
        waitfor(reqReady, 1'b1);
        check("reqReady", reqReady, 1'b1);
        @(posedge clock);
        reqValid <= 1'b0;
        waitfor(reqReady, 1'b1);
    endtask : req
    // Waits for a busy interval to start and end.
    task busy_cycle;
        waitfor(flashReady, 1'b0);
        check("flashReady low", flashReady, 1'b0);
        waitfor(flashReady, 1'b1);
        check("flashReady high", flashReady, 1'b1);
    endtask : busy_cycle

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        check("reset csN", chipSelectN, 1'b1);
        check("reset lock", programLockN, 1'b0);
        check("reset ioOe", ioOe, 1'b0);
        rstn <= 1'b1;
        repeat (50) @(negedge clock);
        check("power wait", reqReady, 1'b0);
        check("strobe idle", inputStrobeN, 1'b1);
        foreach (rows[i]) begin
            req(rows[i].op, rows[i].d, rows[i].a);
            case (rows[i].op)
                NHC_OP_CMD: check("cmd", m_u.lastCmd, rows[i].d[7:0]);
                NHC_OP_ADDR: begin
                    check("addr", {m_u.addrByte[3], m_u.addrByte[2], m_u.addrByte[1], m_u.addrByte[0]},
                        {6'h00, AD[26:25], AD[24:17], AD[16:9], AD[7:0]});
                    col = AD[7:0];
                end
                default: begin
                    check("data", m_u.page[col], rows[i].d);
                    col++;
                end
            endcase
        end
        req(NHC_OP_CMD, 16'h0010, 0);
        busy_cycle();
        req(NHC_OP_CMD, 16'h0000, 0);
        req(NHC_OP_ADDR, 16'h0000, AD);
        busy_cycle();
        for (k = 0; k < 8; k++) begin
            @(posedge clock);
            reqOp <= NHC_OP_READ; reqValid <= 1'b1;
            waitfor(reqReady, 1'b1);
            @(posedge clock);
            reqValid <= 1'b0;
            repeat (20) @(posedge clock);
        end
        @(posedge clock);
        reqValid <= 1'b1;
        p = 0;
        repeat (30) begin @(negedge clock); p += reqReady; end
        check("full refuses", p, 0);
        @(posedge clock);
        reqValid <= 1'b0; rdReady <= 1'b1;
        for (k = 0; k < 8; k++) begin
            waitfor(rdValid, 1'b1);
            check("read word", rdData, k < 4 ? rows[k + 2].d : 16'hFFFF);
        end
        @(posedge clock);
        rdReady <= 1'b0;
        @(negedge clock);
        check("fifo empty", rdValid, 1'b0);
        @(posedge clock);
        protectReq <= 1'b1;
        repeat (3) @(negedge clock);
        check("lock low", programLockN, 1'b0);
        p = m_u.progCount;
        req(NHC_OP_CMD, 16'h0080, 0);
        req(NHC_OP_ADDR, 16'h0000, AD);
        req(NHC_OP_CMD, 16'h0010, 0);
        k = 0;
        repeat (60) begin @(negedge clock); k += !flashReady; end
        check("locked busy", k, 0);
        check("locked prog", m_u.progCount, p);
        @(posedge clock);
        protectReq <= 1'b0;
        repeat (3) @(negedge clock);
        check("lock high", programLockN, 1'b1);
        // Low supply: the part latches nothing, so the last command stays put.
        m_u.powerGood = 1'b0;
        req(NHC_OP_CMD, 16'h0070, 0);
        check("low supply", m_u.lastCmd, 8'h10);
        m_u.powerGood = 1'b1;
        // Reset in mid-run: pins fall back to safe levels and the power wait starts over.
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(negedge clock);
        check("midrun csN", chipSelectN, 1'b1);
        check("midrun lock", programLockN, 1'b0);
        @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(negedge clock);
        check("midrun wait", reqReady, 1'b0);
        req(NHC_OP_CMD, 16'h00FF, 0);
        check("after reset", m_u.lastCmd, 8'hFF);
        give_verdict();
    end

    // Watchdog cuts a hang short.
    initial begin
        #200000;
        check("watchdog", 0, 1);
        give_verdict();
    end
endmodule : nhc_host_bench

// [src/nhc_fifo.sv]
/*
 * Small synchronous FIFO for read data.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module nhc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic             doWr, doRd;

    // =====================================================================
    // Flags and next pointers.
    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    // Advances pointers and count.
    always_comb begin
        wrPtr_nxt = doWr ? ((wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1) : wrPtr_r;
        rdPtr_nxt = doRd ? ((rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1) : rdPtr_r;
        count_nxt = count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    // Registers pointers and count.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage is written only; no reset needed.
    always_ff @(posedge clock) begin
        if (doWr) begin
            mem_r[wrPtr_r] <= inData;
        end
    end
endmodule : nhc_fifo

// [src/nhc_host.sv]
/*
 * Host controller for an asynchronous NAND flash part. Takes command,
 * address, write and read requests and plays them out on the flash pins.
 * Assumes a 100 MHz clock; flash busy and data lanes are asynchronous.
 */
`timescale 1ns/1ps
`include "nhc_map.svh"
module nhc_host
    import nhc_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          reqValid,
    output logic               reqReady,
    input  wire logic [2:0]    reqOp,
    input  wire logic [DW-1:0] reqData,
    input  wire logic [31:0]   reqAddr,
    input  wire logic          protectReq,
    output logic               rdValid,
    input  wire logic          rdReady,
    output logic      [DW-1:0] rdData,
    output logic               flashReady,
    output logic               chipSelectN,
    output logic               cmdLatch,
    output logic               addrLatch,
    output logic               inputStrobeN,
    output logic               output_strobe_n,
    output logic               programLockN,
    output logic      [DW-1:0] ioOut,
    output logic               ioOe,
    input  wire logic [DW-1:0] ioIn,
    input  wire logic          busy_flag_n
);
    localparam logic [7:0] STROBE_CYC = 8'(`NHC_STROBE_CYC);
    localparam logic [7:0] PWRUP_CYC  = 8'(`NHC_PWRUP_CYC);

    typedef enum logic [2:0] {S_POWER, S_IDLE, S_SETUP, S_LOW, S_HIGH} nhc_state_e;

    nhc_state_e    state_r, state_nxt;
    logic [7:0]    cnt_r, cnt_nxt;
    logic [1:0]    addrIdx_r, addrIdx_nxt;
    nhc_op_e       op_r, op_nxt;
    logic [DW-1:0] ioOut_r, ioOut_nxt;
    logic [31:0]   addr_r, addr_nxt;
    logic          cle_r, cle_nxt, ale_r, ale_nxt, weN_r, weN_nxt, reN_r, reN_nxt;
    logic          oe_r, oe_nxt, ceN_r, ceN_nxt, lockN_r, lockN_nxt;
    logic [DW-1:0] ioS1_r, ioS2_r;
    logic          bsyS1_r, bsyS2_r;
    logic          fifoReady, pushRead;

    // =====================================================================
    // Input synchronisers for the data lanes and the busy line.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ioS1_r  <= '0;
            ioS2_r  <= '0;
            bsyS1_r <= 1'b0;
            bsyS2_r <= 1'b0;
        end else begin
            ioS1_r  <= ioIn;
            ioS2_r  <= ioS1_r;
            bsyS1_r <= busy_flag_n;
            bsyS2_r <= bsyS1_r;
        end
    end

    // =====================================================================
    // Read data buffer; a full buffer stalls the next read strobe.
    nhc_fifo #(.WIDTH(DW), .DEPTH(`NHC_FIFO_DEPTH)) u_fifo (
        .clock    (clock),
        .rstn     (rstn),
        .inValid  (pushRead),
        .inReady  (fifoReady),
        .inData   (ioS2_r),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );

    assign flashReady      = bsyS2_r;
    assign reqReady        = (state_r == S_IDLE) && !(reqValid && nhc_op_e'(reqOp) == NHC_OP_READ && !fifoReady);
    // Data reaching the FIFO on the first high cycle was sampled while the read strobe was still low.
    assign pushRead        = (state_r == S_HIGH) && (op_r == NHC_OP_READ) && (cnt_r == STROBE_CYC);
    assign chipSelectN     = ceN_r;
    assign cmdLatch        = cle_r;
    assign addrLatch       = ale_r;
    assign inputStrobeN    = weN_r;
    assign output_strobe_n = reN_r;
    assign programLockN    = lockN_r;
    assign ioOut           = ioOut_r;
    assign ioOe            = oe_r;

    // =====================================================================
    // Bus cycle sequencer: set up strobes, pulse low, hold high.
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = (cnt_r != '0) ? cnt_r - 8'd1 : cnt_r;
        addrIdx_nxt = addrIdx_r;
        op_nxt      = op_r;
        ioOut_nxt   = ioOut_r;
        addr_nxt    = addr_r;
        cle_nxt     = cle_r;
        ale_nxt     = ale_r;
        weN_nxt     = weN_r;
        reN_nxt     = reN_r;
        oe_nxt      = oe_r;
        ceN_nxt     = ceN_r;
        lockN_nxt   = protectReq ? 1'b0 : 1'b1;
        unique case (state_r)
            S_POWER: begin
                lockN_nxt = 1'b0;
                weN_nxt   = 1'b1;
                if (cnt_r == '0) begin
                    state_nxt = S_IDLE;
                end
            end
            S_IDLE: begin
                ceN_nxt = 1'b0;
                oe_nxt  = 1'b0;
                if (reqValid && reqReady) begin
                    op_nxt      = nhc_op_e'(reqOp);
                    addr_nxt    = reqAddr;
                    addrIdx_nxt = '0;
                    state_nxt   = S_SETUP;
                    cnt_nxt     = STROBE_CYC;
                    cle_nxt     = (nhc_op_e'(reqOp) == NHC_OP_CMD);
                    ale_nxt     = (nhc_op_e'(reqOp) == NHC_OP_ADDR);
                    oe_nxt      = (nhc_op_e'(reqOp) != NHC_OP_READ);
                    unique case (nhc_op_e'(reqOp))
                        NHC_OP_CMD:   ioOut_nxt = DW'(reqData[7:0]);
                        NHC_OP_ADDR:  ioOut_nxt = DW'(reqAddr[7:0]);
                        default:      ioOut_nxt = reqData;
                    endcase
                end
            end
            S_SETUP: begin
                if (cnt_r == '0) begin
                    state_nxt = S_LOW;
                    cnt_nxt   = STROBE_CYC;
                    if (op_r == NHC_OP_READ) begin
                        reN_nxt = 1'b0;
                    end else begin
                        weN_nxt = 1'b0;
                    end
                end
            end
            S_LOW: begin
                if (cnt_r == '0) begin
                    state_nxt = S_HIGH;
                    cnt_nxt   = STROBE_CYC;
                    weN_nxt   = 1'b1;
                    reN_nxt   = 1'b1;
                end
            end
            S_HIGH: begin
                if (cnt_r == '0) begin
                    if (op_r == NHC_OP_ADDR && addrIdx_r != 2'(`NHC_ADDR_CYCLES - 1)) begin
                        addrIdx_nxt = addrIdx_r + 2'd1;
                        state_nxt   = S_SETUP;
                        cnt_nxt     = STROBE_CYC;
                        unique case (addrIdx_r)
                            2'd0:    ioOut_nxt = DW'(addr_r[16:9]);
                            2'd1:    ioOut_nxt = DW'(addr_r[24:17]);
                            default: ioOut_nxt = DW'(addr_r[`NHC_A26_BIT:25]);
                        endcase
                    end else begin
                        cle_nxt   = 1'b0;
                        ale_nxt   = 1'b0;
                        oe_nxt    = 1'b0;
                        state_nxt = S_IDLE;
                    end
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // Registers sequencer state and pin levels.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r   <= S_POWER;
            cnt_r     <= PWRUP_CYC;
            addrIdx_r <= '0;
            op_r      <= NHC_OP_CMD;
            ioOut_r   <= '0;
            addr_r    <= '0;
            cle_r     <= 1'b0;
            ale_r     <= 1'b0;
            weN_r     <= 1'b1;
            reN_r     <= 1'b1;
            oe_r      <= 1'b0;
            ceN_r     <= 1'b1;
            lockN_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            addrIdx_r <= addrIdx_nxt;
            op_r      <= op_nxt;
            ioOut_r   <= ioOut_nxt;
            addr_r    <= addr_nxt;
            cle_r     <= cle_nxt;
            ale_r     <= ale_nxt;
            weN_r     <= weN_nxt;
            reN_r     <= reN_nxt;
            oe_r      <= oe_nxt;
            ceN_r     <= ceN_nxt;
            lockN_r   <= lockN_nxt;
        end
    end

    // =====================================================================
    // Checks on the pin sequencing.
    property p_no_double_latch;
        @(posedge clock) disable iff (!rstn) !(cmdLatch && addrLatch);
    endproperty
    a_no_double_latch: assert property (p_no_double_latch) else $error("both latch strobes high");

    property p_read_no_drive;
        @(posedge clock) disable iff (!rstn) !output_strobe_n |-> !ioOe && !cmdLatch && !addrLatch && inputStrobeN;
    endproperty
    a_read_no_drive: assert property (p_read_no_drive) else $error("drive during read strobe");

    property p_write_setup;
        @(posedge clock) disable iff (!rstn) $fell(inputStrobeN) |-> ioOe && !chipSelectN && output_strobe_n;
    endproperty
    a_write_setup: assert property (p_write_setup) else $error("write strobe without setup");

    property p_strobe_width;
        @(posedge clock) disable iff (!rstn) $fell(inputStrobeN) |-> !inputStrobeN [*4];
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short");

    property p_lock_follows;
        @(posedge clock) disable iff (!rstn) (state_r != S_POWER && protectReq) |=> !programLockN;
    endproperty
    a_lock_follows: assert property (p_lock_follows) else $error("lock not applied");

    property p_addr_low_lanes;
        @(posedge clock) disable iff (!rstn) (addrLatch && ioOe) |-> ioOut[DW-1:8] == '0;
    endproperty
    a_addr_low_lanes: assert property (p_addr_low_lanes) else $error("upper lanes used for address");

    property p_powerup_quiet;
        @(posedge clock) disable iff (!rstn) (state_r == S_POWER) |-> inputStrobeN && !programLockN;
    endproperty
    a_powerup_quiet: assert property (p_powerup_quiet) else $error("activity during power-up wait");

    property p_select_held;
        @(posedge clock) disable iff (!rstn) (state_r != S_POWER && $past(state_r) != S_POWER) |-> !chipSelectN;
    endproperty
    a_select_held: assert property (p_select_held) else $error("select released");
endmodule : nhc_host

// [src/nhc_map.svh]
/*
 * Constants for the flash host controller: pin timing counts, FIFO depth
 * and address layout. Assumes a 100 MHz clock and an asynchronous flash part.
 */
// =====================================================================
`ifndef NHC_MAP_SVH
`define NHC_MAP_SVH
`define NHC_CLK_MHZ       100
`define NHC_PWRUP_NS      1000
`define NHC_PWRUP_CYC     ((`NHC_PWRUP_NS * `NHC_CLK_MHZ + 999) / 1000)
`define NHC_STROBE_NS     40
`define NHC_STROBE_CYC    ((`NHC_STROBE_NS * `NHC_CLK_MHZ + 999) / 1000)
`define NHC_ADDR_CYCLES   4
`define NHC_FIFO_DEPTH    8
`define NHC_A26_BIT       26
`endif

// [src/nhc_pkg.sv]
/*
 * Types for the flash host controller.
 * Assumes nothing of its surroundings.
 */
package nhc_pkg;
    // Bus operation kind requested on the user port.
    typedef enum logic [2:0] {
        NHC_OP_CMD,
        NHC_OP_ADDR,
        NHC_OP_WRITE,
        NHC_OP_READ
    } nhc_op_e;
endpackage : nhc_pkg
